//--- rtl/mpeb_defines.svh
// Timing counts, pin phases and reset values for the port and expansion bus block
`ifndef MPEB_DEFINES_SVH
`define MPEB_DEFINES_SVH
// Oscillator periods in one machine cycle
`define MPEB_MC_PERIODS 4'd12
// Oscillator periods between strobe pulses
`define MPEB_HALF_PERIODS 4'd6
// Last state code of the six-state machine cycle
`define MPEB_LAST_STATE 3'd5
// Reset pin hold: two machine cycles of oscillator periods
`define MPEB_RST_HOLD_CYC 5'd24
// First program address that is no longer in internal ROM
`define MPEB_INT_ROM_TOP 16'h2000
// Address-latch pulse length within each half, in periods
`define MPEB_ALE_LEN 3'd2
// Low address drive length on port 0 within each half
`define MPEB_ADDR_LEN 3'd3
// Position within a half where the fetch strobe starts
`define MPEB_PROGRAM_FETCH_STROBE_FIRST 3'd3
// Position within a half where the code byte is sampled
`define MPEB_CODE_SAMPLE 3'd5
// Data strobe window within the machine cycle
`define MPEB_XSTB_FIRST 4'd3
`define MPEB_XSTB_LAST 4'd10
// Last period of the cycle, where the next operation is chosen
`define MPEB_LAST_IDX 4'd11
// Port latch value after reset
`define MPEB_LATCH_RST 8'hFF
`endif

//--- rtl/mpeb_pkg.sv
// Types shared by the port and expansion bus block
package mpeb_pkg;
  // Kind of bus activity in the current machine cycle
  typedef enum logic [2:0] {BUS_INT, BUS_FETCH, BUS_RD16, BUS_WR16, BUS_RD8, BUS_WR8} mpeb_op_e;
  // Output latches of the four ports
  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } mpeb_latch_s;
  // Request from the core, sampled at the end of each machine cycle
  typedef struct packed {
    logic xacc;
    logic xwrite;
    logic wide;
    logic [15:0] xaddr;
    logic [7:0] wdata;
    logic [15:0] pc;
  } mpeb_req_s;
  // One port's pin drive: level, strong drive enable, weak pullup
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } mpeb_pin_s;
  // Alternate-function inputs handed to the core
  typedef struct packed {
    logic rxd;
    logic ext_irq_zero;
    logic ext_irq_one;
    logic counter0_input;
    logic counter1_input;
    logic timer2_count_input;
    logic timer2_trigger_input;
  } mpeb_alt_in_s;
endpackage : mpeb_pkg

//--- rtl/mpeb_top.sv
// Port pins and external expansion bus sequencer
//
// Summary of operation
// - Ports 1-3 pull high when latch holds one
// - P1.0 timer2 count, P1.1 timer2 trigger
// - Reset after pin high two machine cycles
// - Port 3 alternate functions in fixed order
// - Oscillator divided by two flip-flop
// - Port 2 drives high address, strong ones
// - Eight-bit data access keeps port 2 latch
// - Fetch strobe every six periods, external only
// - Address latch strobe, skipped in second half of data access
// - Select pin high: internal below 8192
// - Port 0 open drain, floats on one
// - Port 0 multiplexes address and data strongly
// - Memory latches on write, drives on read
// - Verification: address on port 1, code on 0
`include "mpeb_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module mpeb_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Device pins
  input wire logic rst_pin,
  input wire logic external_fetch_select,
  input wire logic verify_mode,
  input wire logic [7:0] p0_in,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p2_in,
  input wire logic [7:0] p3_in,
  // Core side
  input wire mpeb_pkg::mpeb_latch_s port_latch,
  input wire mpeb_pkg::mpeb_req_s bus_req,
  input wire logic txd_out,
  input wire logic rxd_out,
  input wire logic [7:0] rom_data,
  // Pin drive
  output mpeb_pkg::mpeb_pin_s p0_pin_ff,
  output mpeb_pkg::mpeb_pin_s p1_pin_ff,
  output mpeb_pkg::mpeb_pin_s p2_pin_ff,
  output mpeb_pkg::mpeb_pin_s p3_pin_ff,
  output logic ale_ff,
  output logic program_fetch_strobe_n_ff,
  // Results to core
  output logic core_reset_ff,
  output logic [7:0] code_byte_ff,
  output logic code_valid_ff,
  output logic [7:0] xdata_ff,
  output logic xdata_valid_ff,
  output logic [7:0] verify_addr_ff,
  output mpeb_pkg::mpeb_alt_in_s alt_in_ff
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Period index within the machine cycle
  function automatic logic [3:0] mpeb_idx(input logic [2:0] st, input logic ph);
    return {st, ph};
  endfunction : mpeb_idx

  // Position within the current six-period half
  function automatic logic [2:0] mpeb_pos(input logic [3:0] ix);
    logic [3:0] p;
    p = (ix >= `MPEB_HALF_PERIODS) ? 4'(ix - `MPEB_HALF_PERIODS) : ix;
    return p[2:0];
  endfunction : mpeb_pos

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  logic phase_ff, nxt_phase;          // Divide-by-two flip-flop
  logic [2:0] state_ff, nxt_state;    // State within machine cycle
  mpeb_pkg::mpeb_op_e op_ff, nxt_op;  // Activity of this cycle
  mpeb_pkg::mpeb_req_s req_ff, nxt_req;
  logic [3:0] idx;
  logic [2:0] pos;
  logic second;

  // Advance the period counter and choose the next operation
  always_comb begin
    idx = mpeb_idx(state_ff, phase_ff);
    pos = mpeb_pos(idx);
    second = (idx >= `MPEB_HALF_PERIODS);
    nxt_phase = ~phase_ff;
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_req = req_ff;
    if (phase_ff) begin
      nxt_state = (state_ff == `MPEB_LAST_STATE) ? 3'h0 : 3'(state_ff + 3'h1);
    end
    if (idx == `MPEB_LAST_IDX) begin
      nxt_req = bus_req;
      if (bus_req.xacc) begin
        // Data access takes priority over a fetch
        unique case ({bus_req.wide, bus_req.xwrite})
          2'b11: nxt_op = mpeb_pkg::BUS_WR16;
          2'b10: nxt_op = mpeb_pkg::BUS_RD16;
          2'b01: nxt_op = mpeb_pkg::BUS_WR8;
          2'b00: nxt_op = mpeb_pkg::BUS_RD8;
        endcase
      // Internal or external fetch, board keeps select low without ROM
      end else if (!external_fetch_select || (bus_req.pc >= `MPEB_INT_ROM_TOP)) begin
        nxt_op = mpeb_pkg::BUS_FETCH;
      end else begin
        nxt_op = mpeb_pkg::BUS_INT;
      end
    end
  end

  // Register sequencer state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 1'b0;
      state_ff <= 3'h0;
      op_ff <= mpeb_pkg::BUS_INT;
      req_ff <= '0;
    end else begin
      phase_ff <= nxt_phase;
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      req_ff <= nxt_req;
    end
  end

  // ----------------------------------------
  // Reset pin qualification
  // ----------------------------------------
  logic [4:0] rst_cnt_ff, nxt_rst_cnt;
  logic nxt_core_reset;

  always_comb begin
    nxt_rst_cnt = rst_pin ? rst_cnt_ff : 5'h00;
    nxt_core_reset = core_reset_ff & rst_pin;
    if (rst_pin && (rst_cnt_ff < `MPEB_RST_HOLD_CYC)) begin
      nxt_rst_cnt = 5'(rst_cnt_ff + 5'h01);
    end
    if (rst_pin && (rst_cnt_ff >= 5'(`MPEB_RST_HOLD_CYC - 5'h01))) begin
      nxt_core_reset = 1'b1;
    end
  end

  // Register reset state; core starts held in reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_ff <= 5'h00;
      core_reset_ff <= 1'b1;
    end else begin
      rst_cnt_ff <= nxt_rst_cnt;
      core_reset_ff <= nxt_core_reset;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  mpeb_pkg::mpeb_pin_s nxt_p0, nxt_p1, nxt_p2, nxt_p3;
  logic nxt_ale, nxt_program_fetch_strobe_n;
  logic fetch_ext, data_acc, wide_acc, rd_acc, wr_acc, xstb;
  logic [15:0] fetch_addr;
  logic [7:0] p3_eff;

  // Decode pin levels for this period
  always_comb begin
    fetch_ext = (op_ff == mpeb_pkg::BUS_FETCH);
    rd_acc = (op_ff == mpeb_pkg::BUS_RD16) || (op_ff == mpeb_pkg::BUS_RD8);
    wr_acc = (op_ff == mpeb_pkg::BUS_WR16) || (op_ff == mpeb_pkg::BUS_WR8);
    data_acc = rd_acc || wr_acc;
    wide_acc = (op_ff == mpeb_pkg::BUS_RD16) || (op_ff == mpeb_pkg::BUS_WR16);
    xstb = data_acc && (idx >= `MPEB_XSTB_FIRST) && (idx <= `MPEB_XSTB_LAST);
    fetch_addr = second ? 16'(req_ff.pc + 16'h0001) : req_ff.pc;
    // Address latch strobe, skipped in second half of data access
    nxt_ale = (pos < `MPEB_ALE_LEN) && !(data_acc && second);
    // Fetch strobe only while fetching externally
    nxt_program_fetch_strobe_n = !(fetch_ext && (pos >= `MPEB_PROGRAM_FETCH_STROBE_FIRST));
    nxt_p1.out = port_latch.p1;
    nxt_p1.oe = ~port_latch.p1;
    nxt_p1.pu = port_latch.p1;
    // Port 3 alternate outputs; latch zero overrides them
    p3_eff = port_latch.p3 & {~(rd_acc && xstb), ~(wr_acc && xstb), 4'hF, txd_out, rxd_out};
    nxt_p3.out = p3_eff;
    nxt_p3.oe = ~p3_eff;
    nxt_p3.pu = p3_eff;
    // Port 2: address with strong drive or its own latch
    if (fetch_ext || wide_acc) begin
      nxt_p2.out = fetch_ext ? fetch_addr[15:8] : req_ff.xaddr[15:8];
      nxt_p2.oe = 8'hFF;
      nxt_p2.pu = 8'h00;
    end else begin
      nxt_p2.out = port_latch.p2;
      nxt_p2.oe = ~port_latch.p2;
      nxt_p2.pu = port_latch.p2;
    end
    nxt_p0.out = port_latch.p0;
    nxt_p0.oe = ~port_latch.p0;
    nxt_p0.pu = 8'h00;
    if (verify_mode) begin
      // Code byte out, external pullups give the ones
      nxt_p0.out = rom_data;
      nxt_p0.oe = ~rom_data;
    end else if (fetch_ext || data_acc) begin
      // Multiplexed address and data, strong drive
      nxt_p0.out = fetch_ext ? fetch_addr[7:0] : req_ff.xaddr[7:0];
      nxt_p0.oe = 8'h00;
      if ((pos < `MPEB_ADDR_LEN) && !(data_acc && second)) begin
        nxt_p0.oe = 8'hFF;
      end else if (wr_acc) begin
        // Write data held across the write strobe
        nxt_p0.out = req_ff.wdata;
        nxt_p0.oe = 8'hFF;
      end
    end
  end

  // Register all pin drive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_pin_ff <= {`MPEB_LATCH_RST, 8'h00, 8'h00};
      p1_pin_ff <= {`MPEB_LATCH_RST, 8'h00, `MPEB_LATCH_RST};
      p2_pin_ff <= {`MPEB_LATCH_RST, 8'h00, `MPEB_LATCH_RST};
      p3_pin_ff <= {`MPEB_LATCH_RST, 8'h00, `MPEB_LATCH_RST};
      ale_ff <= 1'b0;
      program_fetch_strobe_n_ff <= 1'b1;
    end else begin
      p0_pin_ff <= nxt_p0;
      p1_pin_ff <= nxt_p1;
      p2_pin_ff <= nxt_p2;
      p3_pin_ff <= nxt_p3;
      ale_ff <= nxt_ale;
      program_fetch_strobe_n_ff <= nxt_program_fetch_strobe_n;
    end
  end

  // ----------------------------------------
  // Input capture
  // ----------------------------------------
  logic [7:0] nxt_code, nxt_xdata, nxt_vaddr;
  logic nxt_code_valid, nxt_xdata_valid;
  mpeb_pkg::mpeb_alt_in_s nxt_alt;

  // Sample bus data and alternate inputs
  always_comb begin
    nxt_code_valid = fetch_ext && (pos == `MPEB_CODE_SAMPLE);
    nxt_code = nxt_code_valid ? p0_in : code_byte_ff;
    // Read data taken at end of read strobe
    nxt_xdata_valid = rd_acc && (idx == `MPEB_XSTB_LAST);
    nxt_xdata = nxt_xdata_valid ? p0_in : xdata_ff;
    nxt_vaddr = p1_in;
    nxt_alt.rxd = p3_in[0];
    nxt_alt.ext_irq_zero = p3_in[2];
    nxt_alt.ext_irq_one = p3_in[3];
    nxt_alt.counter0_input = p3_in[4];
    nxt_alt.counter1_input = p3_in[5];
    nxt_alt.timer2_count_input = p1_in[0];
    nxt_alt.timer2_trigger_input = p1_in[1];
  end

  // Register captured values
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_byte_ff <= 8'h00;
      code_valid_ff <= 1'b0;
      xdata_ff <= 8'h00;
      xdata_valid_ff <= 1'b0;
      verify_addr_ff <= 8'h00;
      alt_in_ff <= '1;
    end else begin
      code_byte_ff <= nxt_code;
      code_valid_ff <= nxt_code_valid;
      xdata_ff <= nxt_xdata;
      xdata_valid_ff <= nxt_xdata_valid;
      verify_addr_ff <= nxt_vaddr;
      alt_in_ff <= nxt_alt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking mpeb_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_DIV_TWO: assert property (1'b1 |=> (phase_ff != $past(phase_ff)))
    else $error("phase flip-flop did not toggle");
  AST_MC_WRAP: assert property ((idx == `MPEB_LAST_IDX) |=> (state_ff == 3'h0) && !phase_ff)
    else $error("machine cycle did not wrap after twelve periods");
  AST_RST_HOLD: assert property ((rst_pin && rst_cnt_ff == 5'd23) |=> core_reset_ff)
    else $error("core reset not raised after hold time");
  AST_RST_EARLY: assert property ($rose(core_reset_ff) |-> $past(rst_cnt_ff) >= 5'd23)
    else $error("core reset raised too early");
  AST_ALE_WIDTH: assert property ($rose(ale_ff) |-> ale_ff[*2] ##1 !ale_ff)
    else $error("address latch pulse not two periods");
  AST_ALE_SKIP: assert property ((data_acc && idx == 4'd6) |=> !ale_ff)
    else $error("address latch pulsed during data access");
  AST_PROGRAM_FETCH_STROBE_INT: assert property ((op_ff == mpeb_pkg::BUS_INT || data_acc) |=> program_fetch_strobe_n_ff)
    else $error("fetch strobe active without external fetch");
  AST_PROGRAM_FETCH_STROBE_LEN: assert property ($fell(program_fetch_strobe_n_ff) |-> !program_fetch_strobe_n_ff[*3] ##1 program_fetch_strobe_n_ff)
    else $error("fetch strobe not low for exactly three periods");
  AST_P2_ADDR: assert property (wide_acc |=> (p2_pin_ff.oe == 8'hFF) && (p2_pin_ff.out == $past(req_ff.xaddr[15:8])))
    else $error("port 2 not driving high address");
  AST_P2_LATCH: assert property ((op_ff == mpeb_pkg::BUS_RD8) |=> (p2_pin_ff.out == $past(port_latch.p2)))
    else $error("port 2 left its latch value");
  AST_P0_FLOAT: assert property ((op_ff == mpeb_pkg::BUS_INT && !verify_mode) |=> (p0_pin_ff.oe == ~$past(port_latch.p0)))
    else $error("port 0 open drain drive wrong");
  AST_RD_DRIVE: assert property ((!p3_pin_ff.out[7]) |-> $past(rd_acc) || !$past(port_latch.p3[7]))
    else $error("read strobe outside read access");

endmodule : mpeb_top
`default_nettype wire

//--- verif/mpeb_ext_mem.sv
// External program and data memory with its address latch
`timescale 1ns/100ps
`default_nettype none
module mpeb_ext_mem (
  // Clock
  input wire logic ref_clk,
  // Bus strobes
  input wire logic ale,
  input wire logic fetch_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // Address and data pins
  input wire logic [7:0] ad_bus,
  input wire logic [7:0] hi_bus,
  // Drive back onto port 0
  output logic [7:0] mem_oe,
  output logic [7:0] mem_out
);
  logic [7:0] lo_ff; // Latched low address
  logic [7:0] hi_ff; // Latched high address
  logic [7:0] ram [256]; // Data store, folded address
  logic [7:0] idx; // Folded address
  assign idx = lo_ff ^ hi_ff;
  // ----------------------------------------
  // Address latch and write capture
  // ----------------------------------------
  // low byte taken while strobe high
  always @(posedge ref_clk) begin
    if (ale) begin
      lo_ff <= ad_bus;
      hi_ff <= hi_bus;
    end
    if (!wr_n) begin
      ram[idx] <= ad_bus;
    end
  end
  // ----------------------------------------
  // Drive only while a strobe is low
  // ----------------------------------------
  // read data and code byte
  always_comb begin
    mem_oe = (!rd_n || !fetch_n) ? 8'hff : 8'h00;
    mem_out = !rd_n ? ram[idx] : (idx ^ 8'h96);
  end
endmodule : mpeb_ext_mem
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the port and expansion bus block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'h0, rst_n = 1'h0, rst_pin = 1'h0; // Clock, resets
  logic external_fetch_select = 1'h1, verify_mode = 1'h0; // Mode pins
  logic txd_out = 1'h1, rxd_out = 1'h1; // Serial outputs
  logic [7:0] rom_data = 8'h00, ext1 = 8'hff, ext3 = 8'hff; // Verify byte, pin pull-downs
  logic [7:0] p0_in, p1_in, p2_in, p3_in, p0_last, m_oe, m_out; // Resolved pins
  mpeb_pkg::mpeb_latch_s port_latch = {8'h3c, 8'ha5, 8'h5c, 8'hff}; // Port latches
  mpeb_pkg::mpeb_req_s bus_req = '0; // Core request
  mpeb_pkg::mpeb_pin_s p0_pin_ff, p1_pin_ff, p2_pin_ff, p3_pin_ff, p0_s, p2_s; // Pin drive
  mpeb_pkg::mpeb_alt_in_s alt_in_ff; // Alternate inputs
  logic ale_ff, program_fetch_strobe_n_ff, core_reset_ff, code_valid_ff, xdata_valid_ff; // Strobes
  logic [7:0] code_byte_ff, xdata_ff, verify_addr_ff, code1; // Results
  int error_cnt = 0, checks = 0, ecnt; // Counters
  int ale_c, str_c, wr_c, rd_c, cv_c, xv_c; // Per-cycle counts
  // Oscillator clock
  always #5 ref_clk = ~ref_clk;
  // Edge count since release, picks machine-cycle boundaries
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ecnt <= 0;
    end else begin
      ecnt <= ecnt + 1;
    end
  end
  // Port 0: device, memory, verify pullups, else unsettled
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p0_in[i] = p0_pin_ff.oe[i] ? p0_pin_ff.out[i] : m_oe[i] ? m_out[i] : verify_mode ? 1'h1 : ~p0_last[i];
    end
  end
  always @(posedge ref_clk) p0_last <= p0_in;
  // Quasi ports: high unless driven or pulled low outside
  assign p1_in = (p1_pin_ff.out | ~p1_pin_ff.oe) & ext1;
  assign p2_in = p2_pin_ff.out | ~p2_pin_ff.oe;
  assign p3_in = (p3_pin_ff.out | ~p3_pin_ff.oe) & ext3;
  mpeb_top dut (.ref_clk, .rst_n, .rst_pin, .external_fetch_select, .verify_mode, .p0_in, .p1_in, .p2_in,
    .p3_in, .port_latch, .bus_req, .txd_out, .rxd_out, .rom_data, .p0_pin_ff, .p1_pin_ff, .p2_pin_ff,
    .p3_pin_ff, .ale_ff, .program_fetch_strobe_n_ff, .core_reset_ff, .code_byte_ff, .code_valid_ff,
    .xdata_ff, .xdata_valid_ff, .verify_addr_ff, .alt_in_ff);
  mpeb_ext_mem mem (.ref_clk, .ale(ale_ff), .fetch_n(program_fetch_strobe_n_ff), .rd_n(p3_in[7]),
    .wr_n(p3_in[6]), .ad_bus(p0_in), .hi_bus(p2_in), .mem_oe(m_oe), .mem_out(m_out));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Present a request and watch the machine cycle that follows
  task automatic do_op(input mpeb_pkg::mpeb_req_s r);
    bus_req = r;
    do @(negedge ref_clk); while (ecnt % 12 != 0);
    bus_req = '0;
    {ale_c, str_c, wr_c, rd_c, cv_c, xv_c} = '0;
    for (int n = 1; n <= 13; n++) begin
      @(negedge ref_clk);
      if (n == 1) begin
        p0_s = p0_pin_ff;
        p2_s = p2_pin_ff;
      end
      if (n <= 12) begin
        ale_c += ale_ff;
        str_c += !program_fetch_strobe_n_ff;
        wr_c += !p3_in[6];
        rd_c += !p3_in[7];
      end
      if (n >= 2) begin
        cv_c += code_valid_ff;
        xv_c += xdata_valid_ff;
        if (code_valid_ff && cv_c == 1) code1 = code_byte_ff;
      end
    end
  endtask : do_op
  // Strobe counts of one machine cycle: periods high or low, not pulses
  task automatic exp_cnt(input int a, input int s, input int w, input int r);
    check(ale_c, a);
    check(str_c, s);
    check(wr_c, w);
    check(rd_c, r);
  endtask : exp_cnt
  // Internal execution: quasi and open-drain ports
  task automatic t_internal;
    do_op('0);
    // Two address-latch pulses of two periods each
    exp_cnt(4, 0, 0, 0);
    check(p1_pin_ff, {8'ha5, 8'h5a, 8'ha5});
    check({p0_s.oe, p0_s.pu}, {8'hc3, 8'h00});
    check(p2_s.out, 8'h5c);
    $display("test internal done");
  endtask : t_internal
  // External fetches, select pin low and at the 8192 boundary
  task automatic t_fetch;
    // board holds select low for all-external code
    external_fetch_select = 1'h0;
    do_op({3'h0, 16'h0000, 8'h00, 16'h1234});
    exp_cnt(4, 6, 0, 0);
    check(cv_c, 2);
    check(code1, 8'h34 ^ 8'h12 ^ 8'h96);
    check(code_byte_ff, 8'h35 ^ 8'h12 ^ 8'h96);
    check({p2_s.out, p2_s.oe, p0_s.out, p0_s.oe}, {8'h12, 8'hff, 8'h34, 8'hff});
    external_fetch_select = 1'h1;
    do_op({3'h0, 16'h0000, 8'h00, 16'h1fff});
    check(str_c, 0);
    do_op({3'h0, 16'h0000, 8'h00, 16'h2000});
    check(str_c, 6);
    check(code1, 8'h20 ^ 8'h96);
    $display("test fetch done");
  endtask : t_fetch
  // Data writes and reads, wide and narrow address
  task automatic t_data;
    do_op({3'h7, 16'h3456, 8'hc3, 16'h0000});
    // Address latch only in the first half of a data cycle
    exp_cnt(2, 0, 8, 0);
    check({p2_s.out, p2_s.oe, p0_s.out}, {8'h34, 8'hff, 8'h56});
    do_op({3'h6, 16'h0077, 8'h3a, 16'h0000});
    check({p2_s.out, p2_s.oe}, {8'h5c, 8'ha3});
    do_op({3'h5, 16'h3456, 8'h00, 16'h0000});
    exp_cnt(2, 0, 0, 8);
    check(xv_c, 1);
    check(xdata_ff, 8'hc3);
    do_op({3'h4, 16'h0077, 8'h00, 16'h0000});
    check(xdata_ff, 8'h3a);
    $display("test data done");
  endtask : t_data
  // Alternate functions on ports 1 and 3; strobe pins kept high
  task automatic t_ports;
    port_latch.p1 = 8'hff;
    ext1 = 8'h02;
    ext3 = 8'hea;
    repeat (3) @(negedge ref_clk);
    check(alt_in_ff, 7'h15);
    ext3 = 8'hff;
    repeat (2) @(negedge ref_clk);
    check(p3_in[1], 1'h1);
    txd_out = 1'h0;
    rxd_out = 1'h0;
    repeat (2) @(negedge ref_clk);
    check(p3_in[1:0], 2'h0);
    txd_out = 1'h1;
    rxd_out = 1'h1;
    // latch zero overrides the serial output
    port_latch.p3 = 8'hfd;
    repeat (2) @(negedge ref_clk);
    check(p3_in[1], 1'h0);
    port_latch.p3 = 8'hff;
    $display("test ports done");
  endtask : t_ports
  // Program verification mode
  task automatic t_verify;
    verify_mode = 1'h1;
    rom_data = 8'ha6;
    ext1 = 8'h3c;
    repeat (3) @(negedge ref_clk);
    check(verify_addr_ff, 8'h3c);
    check(p0_pin_ff.oe, 8'h59);
    check(p0_in, 8'ha6);
    verify_mode = 1'h0;
    $display("test verify done");
  endtask : t_verify
  // Reset pin hold of two machine cycles: rises at the 24th high sample
  task automatic t_rst_pin;
    rst_pin = 1'h1;
    repeat (23) @(negedge ref_clk);
    check(core_reset_ff, 1'h0);
    @(negedge ref_clk);
    check(core_reset_ff, 1'h1);
    rst_pin = 1'h0;
    @(negedge ref_clk);
    check(core_reset_ff, 1'h0);
    $display("test reset pin done");
  endtask : t_rst_pin
  // Counts, verdict, end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    repeat (10) @(negedge ref_clk);
    check({ale_ff, program_fetch_strobe_n_ff, core_reset_ff}, 3'h3);
    rst_n = 1'h1;
    t_internal;
    t_fetch;
    t_data;
    t_ports;
    t_verify;
    t_rst_pin;
    finish_test;
  end
  // Watchdog well beyond the planned run
  initial begin
    #200_000;
    error_cnt++;
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
